// ### design/drc_defs.vh
// offsets, field positions, reset values and timing counts of the refresh controller
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH
`define DRC_CFG_OFF 8'h00
`define DRC_STAT_OFF 8'h04
`define DRC_ADDR_OFF 8'h08
`define DRC_CFG_EXT 0
`define DRC_CFG_ROW_LSB 1
`define DRC_CFG_TYPE 3
`define DRC_CFG_PER_LSB 4
`define DRC_CFG_BANK_LSB 8
`define DRC_CFG_RST 11'h000
`define DRC_LOW_BASE 4'h2
`define DRC_PRE_BASE 4'h1
`define DRC_PRE_RST 4'hF
`define DRC_CLK_NS 40
`define DRC_STEP_NS 1000
`define DRC_STEP_CYC (`DRC_STEP_NS / `DRC_CLK_NS)
`define DRC_RESP_OK 2'h0
`define DRC_RESP_DEC 2'h3
`endif

// ### design/drc_refresh_ctrl.v
// refresh engine of the dram controller with an axi4-lite register slave
// Notes on behaviour
// - config external-mode bit 0 selects automatic internally timed refresh
// - external-mode bit 1: each refresh is requested on the external request input
// - in-progress output asserts one period before first refresh row strobe
// - refresh address counter increments when all refresh row strobes negate
// - refresh row strobe low time set by row timing bits
// - internal timer raises refresh request once per programmed period
// - refresh starts only with no access and precharge met
// - refresh may slot between accesses, never interrupts one
// - in external mode the write strobe pin carries the refresh request
// - request output asserts on expiry, blips high per further missed period
// - low external request sets latch; refresh starts when access and precharge allow
// - external request latch clears when last refresh row strobe negates
// - request held past end edge starts another refresh, timing kept
// - conventional: all strobes low together, negate with in-progress on last edge
// - type bit 0 selects conventional all-strobe refresh
// - offset refresh steps strobe groups per edge, each keeps its low time
// - precharge kept before refresh, after refresh, and between burst refreshes
// - scrubbing chosen by bank bits with type bit 0, not with offset
// - counter is row, column, bank from lsb; 22 or 24 bits
// - during scrubbing, counter bank bits pick which column strobes assert
// - only all-strobe refresh extends; extend input resampled each edge
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "drc_defs.vh"
module drc_refresh_ctrl #(
    parameter ROW_W = 10,
    parameter STEP_CYC = `DRC_STEP_CYC
) (
    input wire clk,
    input wire rst_b,
    input wire clkEn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire accessRequest_n,
    input wire secondPortAccessRequest_n,
    input wire accessActive,
    input wire extRefreshReqIn_n,
    input wire extendRefreshIn,
    input wire writeStrobeIn_n,
    output wire refreshInProgress_n,
    output wire [3:0] rowStrobe_n,
    output wire [3:0] colStrobe_n,
    output wire writeStrobe_n,
    output wire accessHold,
    output wire [ROW_W-1:0] dramAddrOut
);
    localparam AW = 2 * ROW_W + 2;
    // one-hot refresh states: idle, in-progress armed, row strobes low
    localparam ST_IDLE = 3'b001;
    localparam ST_ARM = 3'b010;
    localparam ST_LOW = 3'b100;

    reg [10:0] cfg_q;
    reg [2:0] st_q;
    reg [3:0] tick_q;
    reg [3:0] preCnt_q;
    reg rfPre_q;
    reg autoReq_q;
    reg extLatch_q;
    reg reqOutPend_q;
    reg reqOutBlip_q;
    reg [AW-1:0] rfAddr_q;
    reg [7:0] awAddr_q;
    reg awHave_q;
    reg wHave_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;

    wire extMode;
    wire [1:0] rowTim;
    wire typeStag;
    wire [3:0] perSel;
    wire [2:0] bankCfg;
    wire scrub;
    wire [3:0] lowCyc;
    wire [3:0] preCyc;
    wire [3:0] maxD;
    wire [3:0] lastTick;
    wire accessBusy;
    wire preMet;
    wire reqPend;
    wire startNow;
    wire lowNow;
    wire atLast;
    wire extendNow;
    wire endNow;
    wire timerTick;
    wire anyRowLow;
    wire [1:0] bankSel;
    wire doWrite;
    wire [3:0] rowLow;
    wire [3:0] colLow;

    // configuration register fields
    assign extMode = cfg_q[`DRC_CFG_EXT];
    assign rowTim = cfg_q[`DRC_CFG_ROW_LSB+1:`DRC_CFG_ROW_LSB];
    assign typeStag = cfg_q[`DRC_CFG_TYPE];
    assign perSel = cfg_q[`DRC_CFG_PER_LSB+3:`DRC_CFG_PER_LSB];
    assign bankCfg = cfg_q[`DRC_CFG_BANK_LSB+2:`DRC_CFG_BANK_LSB];
    // scrubbing only with the conventional type
    assign scrub = bankCfg[2] & ~typeStag;
    assign lowCyc = {2'b00, rowTim} + `DRC_LOW_BASE;
    assign preCyc = {2'b00, rowTim} + `DRC_PRE_BASE;
    // last group offset: singles 3, pairs 1, all 0
    assign maxD = !typeStag ? 4'h0 : (bankCfg[1:0] == 2'b00) ? 4'h3 :
        (bankCfg[1:0] == 2'b01) ? 4'h1 : 4'h0;
    assign lastTick = maxD + lowCyc - 4'h1;

    // arbitration inputs and refresh timing compare
    assign accessBusy = ~accessRequest_n | ~secondPortAccessRequest_n | accessActive;
    assign preMet = (preCnt_q >= preCyc);
    assign reqPend = extMode ? extLatch_q : autoReq_q;
    assign startNow = st_q[0] & reqPend & ~accessBusy & preMet;
    assign lowNow = st_q[2];
    assign atLast = lowNow & (tick_q == lastTick);
    assign extendNow = atLast & ~typeStag & extendRefreshIn;
    assign endNow = atLast & ~extendNow;
    assign anyRowLow = |rowLow;
    assign bankSel = rfAddr_q[AW-1:AW-2];

    drc_refresh_timer #(
        .STEP_CYC(STEP_CYC),
        .CW(10)
    ) uTimer (
        .clk(clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .periodSel(perSel),
        .tick(timerTick)
    );

    // per-strobe row and column strobe timing
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : gStrobe
            wire [3:0] dly;
            wire [31:0] giFull;
            wire [3:0] gidx;
            wire colSel;
            assign giFull = gi;
            assign gidx = giFull[3:0];
            assign dly = !typeStag ? 4'h0 : (bankCfg[1:0] == 2'b00) ? gidx :
                (bankCfg[1:0] == 2'b01) ? {1'b0, gidx[3:1]} : 4'h0;
            assign rowLow[gi] = lowNow & (tick_q >= dly) &
                (tick_q < dly + lowCyc || extendNow);
            assign colSel = (bankCfg[1:0] == 2'b00) ? (gidx[1:0] == bankSel) :
                (bankCfg[1:0] == 2'b01) ? (gidx[1] == bankSel[1]) : 1'b1;
            assign colLow[gi] = lowNow & scrub & colSel & (tick_q != 4'h0);
        end
    endgenerate

    // pin outputs, all active low except the access hold and the refresh address
    assign rowStrobe_n = ~rowLow;
    assign colStrobe_n = ~colLow;
    assign refreshInProgress_n = ~(st_q[1] | st_q[2]);
    assign writeStrobe_n = extMode ? ~(reqOutPend_q & ~reqOutBlip_q) :
        writeStrobeIn_n;
    assign accessHold = ~st_q[0] | rfPre_q | startNow;
    assign dramAddrOut = rfAddr_q[ROW_W-1:0];

    // arbitration and refresh sequencing
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            st_q <= ST_IDLE;
            tick_q <= 4'h0;
        end
        else if (clkEn)
        begin
            case (st_q)
                ST_IDLE:
                begin
                    tick_q <= 4'h0;
                    if (startNow)
                        st_q <= ST_ARM;
                end
                ST_ARM:
                begin
                    tick_q <= 4'h0;
                    st_q <= ST_LOW;
                end
                ST_LOW:
                begin
                    if (endNow)
                        st_q <= ST_IDLE;
                    else if (!atLast)
                        tick_q <= tick_q + 4'h1;
                end
                default:
                begin
                    st_q <= ST_IDLE;
                    tick_q <= 4'h0;
                end
            endcase
        end
    end

    // precharge counting, request latches and the address counter
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            preCnt_q <= `DRC_PRE_RST;
            rfPre_q <= 1'b0;
            autoReq_q <= 1'b0;
            extLatch_q <= 1'b0;
            reqOutPend_q <= 1'b0;
            reqOutBlip_q <= 1'b0;
            rfAddr_q <= {AW{1'b0}};
        end
        else if (clkEn)
        begin
            if (accessBusy || anyRowLow)
                preCnt_q <= 4'h0;
            else if (!preMet)
                preCnt_q <= preCnt_q + 4'h1;
            if (endNow)
                rfPre_q <= 1'b1;
            else if (preMet)
                rfPre_q <= 1'b0;
            autoReq_q <= (timerTick & ~extMode) | (autoReq_q & ~endNow);
            extLatch_q <= (~extRefreshReqIn_n & extMode) |
                (extLatch_q & ~endNow);
            reqOutPend_q <= (timerTick & extMode) | (reqOutPend_q & ~endNow);
            reqOutBlip_q <= timerTick & extMode & reqOutPend_q & ~endNow;
            if (endNow)
                rfAddr_q <= rfAddr_q + {{(AW-1){1'b0}}, 1'b1};
        end
    end

    // axi4-lite write path: address and data taken in either order
    assign s_axi_awready = clkEn & ~awHave_q & ~s_axi_bvalid;
    assign s_axi_wready = clkEn & ~wHave_q & ~s_axi_bvalid;
    // write lands once both address and data are held
    assign doWrite = awHave_q & wHave_q & ~s_axi_bvalid;

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            cfg_q <= `DRC_CFG_RST;
            awAddr_q <= 8'h00;
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DRC_RESP_OK;
        end
        else if (clkEn)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awAddr_q <= s_axi_awaddr;
                awHave_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                wHave_q <= 1'b1;
            end
            if (doWrite)
            begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `DRC_RESP_OK;
                if (awAddr_q[7:2] == `DRC_CFG_OFF >> 2)
                begin
                    if (wStrb_q[0])
                        cfg_q[7:0] <= wData_q[7:0];
                    if (wStrb_q[1])
                        cfg_q[10:8] <= wData_q[10:8];
                end
                else if (awAddr_q[7:2] != `DRC_STAT_OFF >> 2 &&
                    awAddr_q[7:2] != `DRC_ADDR_OFF >> 2)
                    s_axi_bresp <= `DRC_RESP_DEC;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // axi4-lite read path: answer one cycle after the address is taken
    assign s_axi_arready = clkEn & ~s_axi_rvalid;

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DRC_RESP_OK;
        end
        else if (clkEn)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `DRC_RESP_OK;
                s_axi_rdata <= 32'h00000000;
                case (s_axi_araddr[7:2])
                    `DRC_CFG_OFF >> 2:
                        s_axi_rdata <= {21'h00000, cfg_q};
                    `DRC_STAT_OFF >> 2:
                        s_axi_rdata <= {28'h0000000, reqOutPend_q, rfPre_q,
                            reqPend, ~refreshInProgress_n};
                    `DRC_ADDR_OFF >> 2:
                        s_axi_rdata <= {{(32-AW){1'b0}}, rfAddr_q};
                    default:
                        s_axi_rresp <= `DRC_RESP_DEC;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### design/drc_refresh_timer.v
// refresh period timer: one tick per programmed period
`timescale 1ns/1ns
`default_nettype none
`include "drc_defs.vh"
module drc_refresh_timer #(
    parameter STEP_CYC = `DRC_STEP_CYC,
    parameter CW = 10
) (
    input wire clk,
    input wire rst_b,
    input wire clkEn,
    input wire [3:0] periodSel,
    output reg tick
);
    wire [CW-1:0] stepC;
    wire [CW-1:0] mult;
    wire [2*CW-1:0] prod;
    wire [CW-1:0] reloadVal;
    reg [CW-1:0] cnt_q;
    assign stepC = STEP_CYC[CW-1:0];
    assign mult = {{(CW-4){1'b0}}, periodSel} + {{(CW-1){1'b0}}, 1'b1};
    assign prod = mult * stepC;
    assign reloadVal = prod[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
    // counts down, reloads and ticks once per period
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            cnt_q <= {CW{1'b0}};
            tick <= 1'b0;
        end
        else if (clkEn)
        begin
            tick <= (cnt_q == {CW{1'b0}});
            if (cnt_q == {CW{1'b0}})
                cnt_q <= reloadVal;
            else
                cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

// ### dv/drc_host_model.sv
// host access model: overlapped two-port access on command
`timescale 1ns/1ns
`default_nettype none
module drc_host_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic accessHold,
    output logic accessRequest_n,
    output logic secondPortAccessRequest_n,
    output logic accessActive
);
    logic [3:0] len_q;
    always @(posedge clk)
    begin
        if (!rst_b)
            len_q <= 4'h0;
        else if (len_q != 4'h0)
            len_q <= len_q - 4'h1;
        else if (go && !accessHold)
            len_q <= 4'hA;
    end
    assign accessRequest_n = !(len_q > 4'h4);
    assign secondPortAccessRequest_n = !(len_q != 4'h0 && len_q < 4'h6);
    assign accessActive = len_q > 4'h2;
endmodule
`default_nettype wire

// ### dv/drc_refresh_chk.sv
// port checker for the refresh engine
`timescale 1ns/1ns
`default_nettype none
module drc_refresh_chk #(
    parameter ROW_W = 10
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic accessRequest_n,
    input wire logic secondPortAccessRequest_n,
    input wire logic accessActive,
    input wire logic refreshInProgress_n,
    input wire logic [3:0] rowStrobe_n,
    input wire logic [3:0] colStrobe_n,
    input wire logic accessHold,
    input wire logic [ROW_W-1:0] dramAddrOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    rows_need_refresh_in_progress_a: assert property (rowStrobe_n != 4'hF |-> !refreshInProgress_n)
        else $error("row strobe low outside refresh");
    first_row_a: assert property ($fell(refreshInProgress_n) |=> !rowStrobe_n[0])
        else $error("first row strobe late");
    idle_start_a: assert property ($fell(refreshInProgress_n) |-> $past(accessRequest_n)
        && $past(secondPortAccessRequest_n) && !$past(accessActive)) else $error("start busy");
    addr_step_a: assert property ($rose(refreshInProgress_n)
        |-> dramAddrOut == ROW_W'($past(dramAddrOut) + 1'b1)) else $error("counter step");
    rows_end_a: assert property ($rose(refreshInProgress_n) |-> rowStrobe_n == 4'hF)
        else $error("strobes outlive refresh");
    low_min_a: assert property ($fell(rowStrobe_n[0]) |=> !rowStrobe_n[0])
        else $error("row low too short");
    pre_gap_a: assert property ($rose(rowStrobe_n[3]) |=> rowStrobe_n[3])
        else $error("no precharge");
    col_in_ref_a: assert property (colStrobe_n != 4'hF |-> rowStrobe_n != 4'hF)
        else $error("column strobe outside refresh");
    hold_in_ref_a: assert property (!refreshInProgress_n |-> accessHold)
        else $error("access not held");
endmodule
bind drc_refresh_ctrl drc_refresh_chk #(.ROW_W(ROW_W)) uChk (
    .clk(clk), .rst_b(rst_b), .accessRequest_n(accessRequest_n),
    .secondPortAccessRequest_n(secondPortAccessRequest_n), .accessActive(accessActive),
    .refreshInProgress_n(refreshInProgress_n), .rowStrobe_n(rowStrobe_n),
    .colStrobe_n(colStrobe_n), .accessHold(accessHold), .dramAddrOut(dramAddrOut)
);
`default_nettype wire

// ### dv/drc_refresh_ctrl_tb_top.sv
// self-checking bench for the refresh engine
`timescale 1ns/1ns
`default_nettype none
module drc_refresh_ctrl_tb_top;
    logic clk = '0, rst_b = '0, go = '0, extend = '0, extReq_n = '1, wsIn_n = '1;
    logic awValid = '0, wValid = '0, bReady = '0, arValid = '0, rReady = '0;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0] wData = 32'h0, rData;
    logic [1:0] bResp, rResp;
    logic awReady, wReady, bValid, arReady, rValid, accReq_n, acc2_n, accAct;
    logic refresh_in_progress_n, wsOut_n, hold;
    logic [3:0] rows_n, cols_n;
    logic [9:0] addr, a;
    int n_fail = 0, n_tests = 0, lowCnt = 0, cyc = 0, t0;
    initial forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (!rows_n[0])
            lowCnt <= lowCnt + 1;
    end
    drc_refresh_ctrl #(.ROW_W(10), .STEP_CYC(2)) dut (
        .clk(clk), .rst_b(rst_b), .clkEn(1'h1), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .accessRequest_n(accReq_n), .secondPortAccessRequest_n(acc2_n), .accessActive(accAct),
        .extRefreshReqIn_n(extReq_n), .extendRefreshIn(extend), .writeStrobeIn_n(wsIn_n),
        .refreshInProgress_n(refresh_in_progress_n), .rowStrobe_n(rows_n), .colStrobe_n(cols_n),
        .writeStrobe_n(wsOut_n), .accessHold(hold), .dramAddrOut(addr)
    );
    drc_host_model host (
        .clk(clk), .rst_b(rst_b), .go(go), .accessHold(hold), .accessRequest_n(accReq_n),
        .secondPortAccessRequest_n(acc2_n), .accessActive(accAct)
    );
    task results();
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task tmo();
        n_fail++;
        results();
    endtask
    task wt(input int s, input logic v);
        logic x;
        for (int i = 0; i < 300; i++)
        begin
            @(negedge clk);
            x = s == 0 ? refresh_in_progress_n : s == 1 ? wsOut_n : accAct;
            @(posedge clk);
            if (x === v)
                return;
        end
        tmo();
    endtask
    task axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] e);
        logic ta, tw, tb;
        logic [1:0] r;
        awAddr <= ad;
        wData <= d;
        awValid <= '1;
        wValid <= '1;
        bReady <= '1;
        tb = '0;
        for (int i = 0; i < 50 && !tb; i++)
        begin
            @(negedge clk);
            ta = awValid && awReady;
            tw = wValid && wReady;
            tb = bValid;
            r = bResp;
            @(posedge clk);
            if (ta) awValid <= '0;
            if (tw) wValid <= '0;
        end
        if (!tb) tmo();
        chk(32'(r), 32'(e));
    endtask
    task axr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] e);
        logic ta, tr;
        logic [31:0] q;
        logic [1:0] r;
        arAddr <= ad;
        arValid <= '1;
        rReady <= '1;
        tr = '0;
        for (int i = 0; i < 50 && !tr; i++)
        begin
            @(negedge clk);
            ta = arValid && arReady;
            tr = rValid;
            q = rData;
            r = rResp;
            @(posedge clk);
            if (ta) arValid <= '0;
        end
        if (!tr) tmo();
        chk(q, d);
        chk(32'(r), 32'(e));
    endtask
    task pulse();
        extReq_n <= '0;
        @(posedge clk);
        extReq_n <= '1;
    endtask
    task tRegs();
        axr(8'h00, 32'h0, 2'h0);
        axw(8'h0C, 32'h1, 2'h3);
        axr(8'h0C, 32'h0, 2'h3);
        $display("regs done");
    endtask
    task tConv();
        axw(8'h00, 32'h3, 2'h0);
        wt(0, 1);
        a = addr;
        pulse();
        wt(0, 0);
        lowCnt <= 0;
        @(negedge clk);
        chk(32'(rows_n), 32'h0);
        wt(0, 1);
        chk(lowCnt, 32'h3);
        chk(32'(addr), 32'(a + 10'h1));
        axr(8'h08, 32'(a) + 32'h1, 2'h0);
        repeat (20) @(posedge clk);
        chk(32'(addr), 32'(a + 10'h1));
        axr(8'h04, 32'h8, 2'h0);
        $display("conventional done");
    endtask
    task tBurst();
        a = addr;
        extReq_n <= '0;
        wt(0, 0);
        wt(0, 1);
        wt(0, 0);
        extReq_n <= '1;
        wt(0, 1);
        repeat (20) @(posedge clk);
        chk(32'(addr), 32'(a + 10'h2));
        $display("burst done");
    endtask
    task tOff();
        logic [3:0] ofs [6] = '{4'hE, 4'hC, 4'h9, 4'h3, 4'h7, 4'hF};
        axw(8'h00, 32'h9, 2'h0);
        pulse();
        wt(0, 0);
        for (int k = 0; k < 6; k++)
        begin
            @(negedge clk);
            chk(32'(rows_n), 32'(ofs[k]));
        end
        wt(0, 1);
        $display("offset done");
    endtask
    task tExt();
        axw(8'h00, 32'h1, 2'h0);
        pulse();
        wt(0, 0);
        lowCnt <= 0;
        @(posedge clk);
        extend <= '1;
        repeat (3) @(posedge clk);
        extend <= '0;
        wt(0, 1);
        chk(lowCnt, 32'h5);
        $display("extend done");
    endtask
    task tScrub();
        axw(8'h00, 32'h401, 2'h0);
        pulse();
        wt(0, 0);
        @(posedge clk);
        @(negedge clk);
        chk(32'(cols_n != 4'hF), 32'h1);
        wt(0, 1);
        $display("scrub done");
    endtask
    task tAcc();
        axw(8'h00, 32'h1, 2'h0);
        a = addr;
        go <= '1;
        wt(2, 1);
        go <= '0;
        pulse();
        wt(0, 0);
        chk(32'(acc2_n), 32'h1);
        wt(0, 1);
        chk(32'(addr), 32'(a + 10'h1));
        $display("access done");
    endtask
    task tAuto();
        axw(8'h00, 32'hF0, 2'h0);
        wsIn_n <= '0;
        wt(0, 0);
        wt(0, 1);
        wt(0, 0);
        wt(0, 1);
        wt(0, 0);
        t0 = cyc;
        wt(0, 1);
        wt(0, 0);
        chk(cyc - t0, 32'h20);
        chk(32'(wsOut_n), 32'h0);
        wsIn_n <= '1;
        @(negedge clk);
        chk(32'(wsOut_n), 32'h1);
        @(posedge clk);
        $display("auto done");
    endtask
    task tReq();
        axw(8'h00, 32'hF1, 2'h0);
        wt(1, 0);
        wt(1, 1);
        @(negedge clk);
        chk(32'(wsOut_n), 32'h0);
        @(posedge clk);
        pulse();
        wt(0, 0);
        wt(0, 1);
        @(negedge clk);
        chk(32'(wsOut_n), 32'h1);
        $display("request done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= '1;
        @(posedge clk);
        tRegs();
        tConv();
        tBurst();
        tOff();
        tExt();
        tScrub();
        tAcc();
        tAuto();
        tReq();
        results();
    end
endmodule
`default_nettype wire
